// *** rtl/dba_pkg.sv ***
// Summary of operation
// - Base register read-only, 32 or 64 bits.
// - Low word bits 31:12 hold base address.
// - High word gives bits 63:32, else zero.
// - Current layout: bits 11:2 read zero.
// - Current layout: format bit 1 reads one.
// - Current layout: bit 0 shows debug entry present.
// - Low word 0xF8, high word 0xF0.
// - Legacy, no entry: fixed no-entry pattern.
// - Legacy address layout: only bits 31:12 set.
// - Legacy never combined with large addresses.
// - Base value is a non-secure address.
// - Dedicated connection split into two 2GB segments.
// - Segmented connection: base address bit 31 set; code forces it only in the current layout with a 32-bit base.
// - Multi-page component: base points at ident page.
// - Components sit low, within one 2GB half.
// - Banked registers map four words, address unchanged.
// - Banked register holds one 32-bit data word.
// - Banked access waits for memory access completion.
// - Banked accesses never increment transfer address.
// - Banked word address: aligned transfer address plus offset.
package dba_pkg;

  // Access port register offsets.
  localparam logic [7:0] DBA_OFF_CSW = 8'h00;
  localparam logic [7:0] DBA_OFF_TAR_LO = 8'h04;
  localparam logic [7:0] DBA_OFF_TAR_HI = 8'h08;
  localparam logic [7:0] DBA_OFF_DRW = 8'h0c;
  localparam logic [3:0] DBA_BANK_PAGE = 4'h1;
  localparam logic [7:0] DBA_OFF_BASE_HI = 8'hf0;
  localparam logic [7:0] DBA_OFF_CFG = 8'hf4;
  localparam logic [7:0] DBA_OFF_BASE_LO = 8'hf8;

  // Base word field layout and fixed values.
  localparam int DBA_BASE_ADDR_LSB = 12;
  localparam int DBA_BASE_FMT_BIT = 1;
  localparam int DBA_BASE_PRESENT_BIT = 0;
  localparam int DBA_SEG_BIT = 31;
  localparam logic [11:0] DBA_BASE_PAD = 12'h000;
  localparam logic [31:0] DBA_NO_ENTRY = 32'h0fffffff;

  // Control status word fields and reset value.
  localparam int DBA_CSW_SIZE_LSB = 0;
  localparam int DBA_CSW_INC_LSB = 4;
  localparam logic [2:0] DBA_SIZE_WORD = 3'h2;
  localparam logic [1:0] DBA_INC_OFF = 2'h0;
  localparam logic [1:0] DBA_INC_SINGLE = 2'h1;
  localparam logic [31:0] DBA_CSW_RESET = 32'h00000002;

  // Configuration word field and address step.
  localparam int DBA_CFG_LA_BIT = 1;
  localparam logic [63:0] DBA_WORD_STEP = 64'h0000000000000004;

  // Access port request and memory request carriers.
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } dba_ap_req_t;

  typedef struct packed {
    logic we;
    logic [63:0] addr;
    logic [31:0] wdata;
  } dba_mem_req_t;

  typedef enum logic [1:0] {DBA_IDLE, DBA_MEM, DBA_DONE} dba_state_t;

endpackage

// *** rtl/dba_base_word.sv ***
`timescale 1ns/1ps
// Forms the two base words from implementation tie-offs.
module dba_base_word import dba_pkg::*; #(
  parameter bit LARGE_ADDR = 1'b0,
  parameter bit LEGACY = 1'b0,
  parameter bit PRESENT = 1'b1,
  parameter bit SEGMENTED = 1'b0,
  parameter logic [63:0] BASE_ADDR = 64'h0000000080000000
) (
  // Base words.
  output logic [31:0] o_base_lo,
  output logic [31:0] o_base_hi
);

  // The legacy layout is dropped when large addresses are on, so the two never mix.
  // legacy excludes large
  localparam bit LEGACY_EFF = LEGACY && !LARGE_ADDR;
  // Segmentation only applies to a 32-bit base.
  localparam bit SEG_EFF = SEGMENTED && !LARGE_ADDR;

  // Words are pure constants, so there is nothing that a write could change.
  // read-only tie-off words
  always_comb begin
    o_base_lo = 32'h00000000;
    o_base_hi = 32'h00000000;
    if (LEGACY_EFF) begin
      if (!PRESENT) begin
        o_base_lo = DBA_NO_ENTRY;
      end else begin
        o_base_lo = {BASE_ADDR[31:DBA_BASE_ADDR_LSB], DBA_BASE_PAD};
      end
    end else begin
      o_base_lo[31:DBA_BASE_ADDR_LSB] = BASE_ADDR[31:DBA_BASE_ADDR_LSB];
      if (SEG_EFF) begin
        o_base_lo[DBA_SEG_BIT] = 1'b1;
      end
      o_base_lo[DBA_BASE_FMT_BIT] = 1'b1;
      o_base_lo[DBA_BASE_PRESENT_BIT] = PRESENT;
      if (LARGE_ADDR) begin
        o_base_hi = BASE_ADDR[63:32];
      end
    end
  end

endmodule

// *** rtl/dba_memory_access_port.sv ***
`timescale 1ns/1ps
// Memory access port register block: base words, transfer address, data and banked data.
module dba_memory_access_port import dba_pkg::*; #(
  parameter bit LARGE_ADDR = 1'b0,
  parameter bit LEGACY = 1'b0,
  parameter bit PRESENT = 1'b1,
  parameter bit SEGMENTED = 1'b0,
  parameter logic [63:0] BASE_ADDR = 64'h0000000080000000
) (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Access port request from the debug port.
  input wire logic i_ap_req,
  input wire dba_ap_req_t i_ap,
  // Access port answer.
  output logic o_ap_ready,
  output logic [31:0] o_ap_rdata,
  output logic o_ap_err,
  // Memory request side.
  output logic o_mem_req,
  output dba_mem_req_t o_mem,
  output logic o_mem_dbg_seg,
  output logic o_mem_nonsecure,
  // Memory answer side.
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  input wire logic i_mem_err
);

  // Banked data page decode, used by the take logic, the address mux and the increment logic.
  function automatic logic is_bank(input logic [7:0] addr);
    is_bank = (addr[7:4] == DBA_BANK_PAGE);
  endfunction

  // Any access that must reach memory before it completes.
  function automatic logic is_mem_access(input logic [7:0] addr);
    is_mem_access = is_bank(addr) || (addr == DBA_OFF_DRW);
  endfunction

  dba_state_t state;
  dba_ap_req_t cur;
  logic [63:0] transfer_address_register;
  logic [63:0] tar_eff;
  logic [2:0] csw_size;
  logic [1:0] csw_inc;
  logic [31:0] base_lo;
  logic [31:0] base_hi;
  logic [31:0] reg_value;
  logic [63:0] next_mem_addr;
  logic take;
  logic take_mem;
  logic mem_done;

  // Base words come from tie-offs only.
  // base kept low
  dba_base_word #(
    .LARGE_ADDR(LARGE_ADDR),
    .LEGACY(LEGACY),
    .PRESENT(PRESENT),
    .SEGMENTED(SEGMENTED),
    .BASE_ADDR(BASE_ADDR)
  ) u_base (
    .o_base_lo(base_lo),
    .o_base_hi(base_hi)
  );

  // A request is taken only while idle; the port holds it until the answer.
  assign take = i_ap_req && (state == DBA_IDLE);
  assign take_mem = take && is_mem_access(i_ap.addr);
  assign mem_done = (state == DBA_MEM) && i_mem_ack;
  assign o_ap_ready = (state == DBA_DONE);

  // Without large addresses the upper transfer address word is reserved and zero.
  assign tar_eff = LARGE_ADDR ? transfer_address_register : {32'h00000000, transfer_address_register[31:0]};

  // Word address for the access being taken.
  always_comb begin
    next_mem_addr = {tar_eff[63:2], 2'b00};
    if (is_bank(i_ap.addr)) begin
      next_mem_addr = {tar_eff[63:4], i_ap.addr[3:2], 2'b00};
    end
  end

  // Register read mux for accesses that do not reach memory.
  always_comb begin
    reg_value = 32'h00000000;
    case (i_ap.addr)
      DBA_OFF_CSW: begin
        reg_value[DBA_CSW_SIZE_LSB +: 3] = csw_size;
        reg_value[DBA_CSW_INC_LSB +: 2] = csw_inc;
      end
      DBA_OFF_TAR_LO: begin
        reg_value = tar_eff[31:0];
      end
      DBA_OFF_TAR_HI: begin
        reg_value = tar_eff[63:32];
      end
      DBA_OFF_BASE_LO: begin
        reg_value = base_lo;
      end
      DBA_OFF_BASE_HI: begin
        reg_value = base_hi;
      end
      DBA_OFF_CFG: begin
        reg_value[DBA_CFG_LA_BIT] = LARGE_ADDR;
      end
      default: begin
        reg_value = 32'h00000000;
      end
    endcase
  end

  // Access sequencing: idle, waiting on memory, answering.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state <= DBA_IDLE;
    end else begin
      case (state)
        DBA_IDLE: begin
          if (take_mem) begin
            state <= DBA_MEM;
          end else if (take) begin
            state <= DBA_DONE;
          end
        end
        DBA_MEM: begin
          if (i_mem_ack) begin
            state <= DBA_DONE;
          end
        end
        DBA_DONE: begin
          state <= DBA_IDLE;
        end
        default: begin
          state <= DBA_IDLE;
        end
      endcase
    end
  end

  // The request is captured so the port may drop it once taken.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cur <= '0;
    end else if (take) begin
      cur <= i_ap;
    end
  end

  // Control status word; only word size is offered, so size writes other than word are kept as word.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      csw_size <= DBA_CSW_RESET[DBA_CSW_SIZE_LSB +: 3];
      csw_inc <= DBA_CSW_RESET[DBA_CSW_INC_LSB +: 2];
    end else if (take && i_ap.wr && (i_ap.addr == DBA_OFF_CSW)) begin
      csw_size <= DBA_SIZE_WORD;
      csw_inc <= i_ap.wdata[DBA_CSW_INC_LSB +: 2];
    end
  end

  // Transfer address: software writes, plus single increment after a data access.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      transfer_address_register <= 64'h0000000000000000;
    end else if (take && i_ap.wr && (i_ap.addr == DBA_OFF_TAR_LO)) begin
      transfer_address_register[31:0] <= i_ap.wdata;
    end else if (take && i_ap.wr && (i_ap.addr == DBA_OFF_TAR_HI) && LARGE_ADDR) begin
      transfer_address_register[63:32] <= i_ap.wdata;
    end else if (mem_done && !is_bank(cur.addr) && (csw_inc == DBA_INC_SINGLE) && !i_mem_err) begin
      transfer_address_register <= LARGE_ADDR ? transfer_address_register + DBA_WORD_STEP : {32'h00000000, transfer_address_register[31:0] + DBA_WORD_STEP[31:0]};
    end
  end

  // Memory request: held from take until the memory acknowledges.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_mem_req <= 1'b0;
    end else if (take_mem) begin
      o_mem_req <= 1'b1;
    end else if (mem_done) begin
      o_mem_req <= 1'b0;
    end
  end

  // Memory address and write data; the banked write data is the word sent to memory.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_mem <= '0;
      o_mem_dbg_seg <= 1'b0;
    end else if (take_mem) begin
      o_mem.we <= i_ap.wr;
      o_mem.addr <= next_mem_addr;
      o_mem.wdata <= i_ap.wdata;
      o_mem_dbg_seg <= SEGMENTED && !LARGE_ADDR ? next_mem_addr[DBA_SEG_BIT] : 1'b1;
    end
  end

  // The base points into non-secure space, so every access from here is marked non-secure.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_mem_nonsecure <= 1'b1;
    end else begin
      o_mem_nonsecure <= 1'b1;
    end
  end

  // Read data: register value at once, or memory data once the access completes.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_ap_rdata <= 32'h00000000;
    end else if (take && !take_mem) begin
      o_ap_rdata <= i_ap.wr ? 32'h00000000 : reg_value;
    end else if (mem_done) begin
      o_ap_rdata <= cur.wr ? 32'h00000000 : i_mem_rdata;
    end
  end

  // Error answer follows the memory error of the access just finished.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_ap_err <= 1'b0;
    end else if (take) begin
      o_ap_err <= 1'b0;
    end else if (mem_done) begin
      o_ap_err <= i_mem_err;
    end
  end

  // Read of the low base word answers next cycle with the tie-off value.
  AST_BASE_LO_READ: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    take && !i_ap.wr && (i_ap.addr == DBA_OFF_BASE_LO) |=> o_ap_ready && (o_ap_rdata == base_lo))
    else $error("Low base word read returned the wrong value.");

  // Without large addresses the high base word reads zero.
  AST_BASE_HI_ZERO: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    take && !i_ap.wr && (i_ap.addr == DBA_OFF_BASE_HI) && !LARGE_ADDR |=> o_ap_rdata == 32'h00000000)
    else $error("High base word not zero in 32-bit build.");

  // Writes to either base word go nowhere: no memory access, and the answer carries zero.
  AST_BASE_RO: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    take && i_ap.wr && ((i_ap.addr == DBA_OFF_BASE_LO) || (i_ap.addr == DBA_OFF_BASE_HI))
    |=> o_ap_ready && !o_mem_req && (o_ap_rdata == 32'h00000000))
    else $error("Base word write had an effect.");

  // Current layout keeps reserved bits clear and the format bit set.
  AST_BASE_FORMAT: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !(LEGACY && !LARGE_ADDR) |-> (base_lo[11:2] == 10'h000) && base_lo[DBA_BASE_FMT_BIT] && (base_lo[0] == PRESENT))
    else $error("Base word format bits are wrong.");

  // Legacy layout with no entry gives the fixed pattern.
  AST_LEGACY_EMPTY: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    LEGACY && !LARGE_ADDR && !PRESENT |-> base_lo == DBA_NO_ENTRY)
    else $error("Legacy no-entry pattern missing.");

  // Segmented connection with a 32-bit base in the current layout reports base bit 31 set.
  AST_SEG_BASE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    SEGMENTED && !LARGE_ADDR && !LEGACY |-> base_lo[DBA_SEG_BIT])
    else $error("Segmented base lacks bit 31.");

  // Banked access issues the aligned word address on the next cycle.
  AST_BANK_ADDR: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    take && is_bank(i_ap.addr) |=> o_mem_req && (o_mem.addr == {$past(tar_eff[63:4]), $past(i_ap.addr[3:2]), 2'b00}))
    else $error("Banked access used the wrong memory address.");

  // The port answer waits while memory has not acknowledged.
  AST_WAIT_MEM: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_mem_req && !i_mem_ack |=> o_mem_req && !o_ap_ready)
    else $error("Access completed before memory did.");

  // Completion of a banked access leaves the transfer address untouched.
  AST_BANK_NO_INC: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    mem_done && is_bank(cur.addr) |=> transfer_address_register == $past(transfer_address_register))
    else $error("Banked access changed the transfer address.");

  // Banked read returns the memory word in the answer cycle.
  AST_BANK_READ: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    mem_done && !cur.wr |=> o_ap_ready && (o_ap_rdata == $past(i_mem_rdata)))
    else $error("Read data not returned from memory.");

  // Segment output follows address bit 31 while a segmented request stands.
  AST_SEG_MARK: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_mem_req && SEGMENTED && !LARGE_ADDR |-> o_mem_dbg_seg == o_mem.addr[DBA_SEG_BIT])
    else $error("Segment mark disagrees with address.");

  // The answer strobe lasts exactly one cycle.
  AST_READY_PULSE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_ap_ready |=> !o_ap_ready)
    else $error("Answer strobe stood longer than one cycle.");

  // The memory request and its payload hold until the memory acknowledges.
  AST_MEM_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem))
    else $error("Memory request changed before acknowledge.");

  // Once memory completes, the request drops and the port answers.
  AST_MEM_DROP: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    mem_done |=> !o_mem_req && o_ap_ready)
    else $error("Port did not answer after memory completion.");

  // Every memory access is marked non-secure.
  AST_NONSECURE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_mem_req |-> o_mem_nonsecure)
    else $error("Memory access not marked non-secure.");

  // Only word accesses leave this port, so the two low address bits stay clear.
  AST_WORD_ALIGN: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_mem_req |-> (o_mem.addr[1:0] == 2'b00))
    else $error("Memory address not word aligned.");

  // A data write carries the port's write word to memory.
  AST_WRITE_DATA: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    take_mem && i_ap.wr |=> o_mem_req && o_mem.we && (o_mem.wdata == $past(i_ap.wdata)))
    else $error("Memory write data differs from the port word.");

  // Legacy address layout keeps only the upper address bits.
  AST_LEGACY_ADDR: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    LEGACY && !LARGE_ADDR && PRESENT |-> (base_lo == {BASE_ADDR[31:12], 12'h000}))
    else $error("Legacy base word layout is wrong.");

  // Large addresses always use the current layout.
  AST_LARGE_FORMAT: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    LARGE_ADDR |-> base_lo[DBA_BASE_FMT_BIT])
    else $error("Legacy layout used with large addresses.");

  // With large addresses the high base word reads the upper address bits.
  AST_BASE_HI_LARGE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    take && !i_ap.wr && (i_ap.addr == DBA_OFF_BASE_HI) && LARGE_ADDR |=> o_ap_rdata == BASE_ADDR[63:32])
    else $error("High base word read returned the wrong value.");

  // Outside a segmented connection every access counts as debugger initiated.
  AST_SEG_FULL: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_mem_req && !(SEGMENTED && !LARGE_ADDR) |-> o_mem_dbg_seg)
    else $error("Unsegmented access not marked as debugger access.");

  // A new access starts with its error answer cleared.
  AST_ERR_CLEAR: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    take |=> !o_ap_err)
    else $error("Stale error answer after a new access.");

endmodule

// *** test/dba_mem_model.sv ***
`timescale 1ns/1ps
// Memory behind the port: one access at a time, answered after a random lag.
module dba_mem_model import dba_pkg::*; (
  // Request from the port.
  input wire logic i_clk_sys,
  input wire logic i_req,
  input wire dba_mem_req_t i_mem,
  input wire logic i_fail,
  // Answer to the port.
  output logic o_ack,
  output logic [31:0] o_rdata,
  output logic o_err
);
  logic [31:0] mem [logic [63:0]];
  // Unwritten words read as the inverted address, so a wrong address shows as wrong data.
  initial begin
    o_ack = 1'b0;
    o_rdata = 32'h0;
    o_err = 1'b0;
    forever begin
      @(posedge i_clk_sys);
      #1;
      if (i_req === 1'b1) begin
        repeat ($urandom_range(0, 3)) begin
          @(posedge i_clk_sys);
          #1;
        end
        o_ack = 1'b1;
        o_err = i_fail;
        if (i_mem.we && !i_fail) begin
          mem[i_mem.addr] = i_mem.wdata;
        end
        o_rdata = mem.exists(i_mem.addr) ? mem[i_mem.addr] : ~i_mem.addr[31:0];
        @(posedge i_clk_sys);
        #1;
        o_ack = 1'b0;
        o_err = 1'b0;
        o_rdata = ~o_rdata; // Released data must not keep looking valid.
      end
    end
  end
endmodule

// *** test/dba_memory_access_port_tb.sv ***
`timescale 1ns/1ps
// Debug port stand-in driving register and memory accesses into the access port.
module dba_memory_access_port_tb import dba_pkg::*;;
  localparam logic [63:0] BASE = 64'h0000000080000000;
  logic i_clk_sys, i_rst, i_ap_req, o_ap_ready, o_ap_err, o_mem_req, o_mem_dbg_seg, o_mem_nonsecure;
  logic mem_ack, mem_err, fail, e;
  logic [31:0] o_ap_rdata, mem_rdata, q, t, d;
  dba_ap_req_t i_ap;
  dba_mem_req_t o_mem;
  logic [63:0] seen_a, wa;
  logic [31:0] seen_d, lo [4], lo_exp [4], hi_exp [4], sh [logic [63:0]];
  logic seen_seg, seen_ns;
  int n_mismatch, comparisons, k, j;

  dba_memory_access_port #(.BASE_ADDR(BASE)) dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ap_req(i_ap_req), .i_ap(i_ap),
    .o_ap_ready(o_ap_ready), .o_ap_rdata(o_ap_rdata), .o_ap_err(o_ap_err), .o_mem_req(o_mem_req),
    .o_mem(o_mem), .o_mem_dbg_seg(o_mem_dbg_seg), .o_mem_nonsecure(o_mem_nonsecure),
    .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata), .i_mem_err(mem_err));
  dba_mem_model mem (.i_clk_sys(i_clk_sys), .i_req(o_mem_req), .i_mem(o_mem), .i_fail(fail),
    .o_ack(mem_ack), .o_rdata(mem_rdata), .o_err(mem_err));
  // Other tie-off sets on the same request stream, so they move in lockstep with the main port.
  // The large-address set also asks for legacy, which must be ignored.
  localparam logic [3:0] CFG_LA = 4'b0001;
  localparam logic [3:0] CFG_LEG = 4'b0111;
  localparam logic [3:0] CFG_PRES = 4'b0101;
  localparam logic [3:0] CFG_SEG = 4'b1000;
  localparam logic [255:0] CFG_BASE = {64'h2000, 64'h40001000, 64'h80000000, 64'h512345000};
  logic [31:0] cfg_rdata [4];
  for (genvar g = 0; g < 4; g++) begin : g_cfg
    dba_memory_access_port #(.LARGE_ADDR(CFG_LA[g]), .LEGACY(CFG_LEG[g]), .PRESENT(CFG_PRES[g]), .SEGMENTED(CFG_SEG[g]),
      .BASE_ADDR(CFG_BASE[64 * g +: 64])) dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ap_req(i_ap_req),
      .i_ap(i_ap), .o_ap_ready(), .o_ap_rdata(cfg_rdata[g]), .o_ap_err(), .o_mem_req(), .o_mem(),
      .o_mem_dbg_seg(), .o_mem_nonsecure(), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata), .i_mem_err(mem_err));
  end

  // Free-running system clock.
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end

  // Record what the memory saw at the edge that completes each access.
  always @(posedge i_clk_sys) begin
    if (mem_ack && o_mem_req) begin
      seen_a = o_mem.addr;
      seen_d = o_mem.wdata;
      seen_seg = o_mem_dbg_seg;
      seen_ns = o_mem_nonsecure;
    end
  end

  function automatic logic [31:0] bw(input logic [63:0] b, input logic f, input logic p);
    return {b[31:12], 10'h0, f, p};
  endfunction

  function automatic logic [31:0] expm(input logic [63:0] a);
    return sh.exists(a) ? sh[a] : ~a[31:0];
  endfunction

  task automatic chk(input string s, input logic [63:0] x, input logic [63:0] g);
    comparisons++;
    if (g !== x) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", s, x, g);
    end
  endtask

  // Request is held until the answer shows, then dropped in that same cycle so it is not taken twice.
  task automatic ap(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
    output logic er);
    int n;
    n = 0;
    @(negedge i_clk_sys);
    i_ap_req = 1'b1;
    i_ap = '{wr: w, addr: a, wdata: wd};
    do begin
      @(negedge i_clk_sys);
      n++;
    end while (o_ap_ready !== 1'b1 && n < 50);
    rd = o_ap_rdata;
    er = o_ap_err;
    i_ap_req = 1'b0;
    chk("answer_seen", 1, n < 50);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // A hang counts as a mismatch; the full run needs only a few hundred cycles.
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    n_mismatch++;
    summarize();
  end

  // Main sequence.
  initial begin
    i_rst = 1'b1;
    i_ap_req = 1'b0;
    i_ap = '0;
    fail = 1'b0;
    void'($urandom(32'h500335a2));
    lo_exp = '{bw(64'h512345000, 1, 1), DBA_NO_ENTRY, bw(64'h40001000, 0, 0), bw(64'h80002000, 1, 0)};
    hi_exp = '{32'h5, 32'h0, 32'h0, 32'h0};
    repeat (8) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    i_rst = 1'b0;
    // Every tie-off set answers the same base word reads through its own port.
    ap(1'b0, DBA_OFF_BASE_LO, 32'h0, q, e);
    lo = cfg_rdata;
    ap(1'b0, DBA_OFF_BASE_HI, 32'h0, q, e);
    foreach (lo[i]) begin
      chk("cfg_base_lo", lo_exp[i], lo[i]);
      chk("cfg_base_hi", hi_exp[i], cfg_rdata[i]);
    end
    ap(1'b0, DBA_OFF_CSW, 32'h0, q, e);
    chk("csw_reset", DBA_CSW_RESET, q);
    // Writes to read-only and unmapped words must leave them unchanged.
    foreach (lo_exp[i]) begin
      k = (i == 3) ? 8'h40 : DBA_OFF_BASE_HI + 8'(4 * i);
      ap(1'b1, 8'(k), $urandom, q, e);
      ap(1'b0, 8'(k), 32'h0, q, e);
      chk("ro_word", (i == 2) ? bw(BASE, 1, 1) : 32'h0, q);
    end
    ap(1'b1, DBA_OFF_CSW, {26'h0, DBA_INC_SINGLE, 1'b0, DBA_SIZE_WORD}, q, e);
    // Banked accesses at random addresses, some failing, with increment on.
    for (int r = 0; r < 24; r++) begin
      t = $urandom;
      d = $urandom;
      k = $urandom_range(0, 3);
      j = $urandom_range(0, 3);
      wa = {32'h0, t[31:4], k[1:0], 2'b00};
      ap(1'b1, DBA_OFF_TAR_LO, t, q, e);
      fail = (r % 6 == 5);
      ap(1'b1, {DBA_BANK_PAGE, k[1:0], 2'b00}, d, q, e);
      chk("bd_wr_addr", wa, seen_a);
      chk("bd_wr_data", d, seen_d);
      chk("bd_err", fail, e);
      if (!fail) begin
        sh[wa] = d;
      end
      fail = 1'b0;
      ap(1'b0, {DBA_BANK_PAGE, j[1:0], 2'b00}, 32'h0, q, e);
      chk("bd_rd_addr", {32'h0, t[31:4], j[1:0], 2'b00}, seen_a);
      chk("bd_rd_data", expm({32'h0, t[31:4], j[1:0], 2'b00}), q);
      ap(1'b0, DBA_OFF_TAR_LO, 32'h0, q, e);
      chk("tar_kept", t, q);
    end
    // Walk the identification words through the data register.
    ap(1'b1, DBA_OFF_TAR_LO, BASE[31:0] + 32'hff0, q, e);
    for (int n = 0; n < 4; n++) begin
      ap(1'b0, DBA_OFF_DRW, 32'h0, q, e);
      chk("ident_addr", BASE + 64'hff0 + 64'(4 * n), seen_a);
      chk("ident_data", expm(BASE + 64'hff0 + 64'(4 * n)), q);
      chk("dbg_seg", 1, seen_seg);
      chk("nonsecure", 1, seen_ns);
    end
    // A failing access must not stop the walk nor move the address.
    fail = 1'b1;
    ap(1'b1, DBA_OFF_DRW, $urandom, q, e);
    chk("drw_err", 1, e);
    fail = 1'b0;
    ap(1'b0, DBA_OFF_TAR_LO, 32'h0, q, e);
    chk("tar_walk", BASE[31:0] + 32'h1000, q);
    summarize();
  end
endmodule
